// ===== rtdc_pkg.sv
// constants and types shared by the rtd channel conditioning block
package rtdc_pkg;
  localparam int NCH = 4;
  localparam int DW = 16;
  localparam int CW = 25;
  localparam int SW = 32;
  localparam int NMAX = 100;
  localparam int QDEPTH = NCH * NMAX;
  localparam int CLK_KHZ = 200000;
  localparam int SLOT_2W_MS = 150;
  localparam int SLOT_3W_MS = 300;
  localparam int BLINK_HALF_MS = 250;
  localparam int SLOT_2W_CYC = SLOT_2W_MS * CLK_KHZ;
  localparam int SLOT_3W_CYC = SLOT_3W_MS * CLK_KHZ;
  localparam int BLINK_CYC = BLINK_HALF_MS * CLK_KHZ;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_MASK = 8'h08;
  localparam logic [7:0] A_ISR = 8'h0C;
  localparam logic [1:0] A_CH_PAGE = 2'h1;
  localparam logic [3:0] SUB_GAIN = 4'h0;
  localparam logic [3:0] SUB_OFS = 4'h4;
  localparam logic [3:0] SUB_WIN = 4'h8;
  localparam logic [3:0] SUB_RES = 4'hC;
  localparam int CTRL_EN_LSB = 0;
  localparam int CTRL_3W_LSB = 4;
  localparam int CTRL_ALM_LSB = 8;
  localparam int CTRL_UNIT_BIT = 12;
  localparam int CTRL_BLINK_BIT = 13;
  localparam int STW = 13;
  localparam int ST_DISC_LSB = 0;
  localparam int ST_RALM_LSB = 4;
  localparam int ST_RWRN_LSB = 8;
  localparam int ST_REJ_BIT = 12;
  localparam logic [13:0] CTRL_RST = 14'h000F;
  localparam logic [12:0] MASK_RST = 13'h0000;
  localparam logic [15:0] GAIN_RST = 16'h4000;
  localparam logic signed [15:0] OFS_RST = 16'sh0000;
  localparam logic [6:0] WIN_RST = 7'h01;
  localparam logic [7:0] ISR_RST = 8'h28;
  localparam logic [15:0] GAIN_MIN = 16'h399A;
  localparam logic [15:0] GAIN_MAX = 16'h4666;
  localparam logic signed [15:0] OFS_MIN = 16'shFF00;
  localparam logic signed [15:0] OFS_MAX = 16'sh0100;
  localparam logic [31:0] WIN_MIN = 32'h00000001;
  localparam logic [31:0] WIN_MAX = 32'h00000064;
  localparam logic [7:0] ISR_MIN = 8'h28;
  localparam logic [7:0] ISR_MAX = 8'hFB;
  localparam logic [17:0] F_MUL = 18'h1CCCD;
  localparam logic signed [SW-1:0] F_ADD = 32'sh00014000;
  localparam logic [5:0] DIV_STEPS = 6'h20;
  typedef enum logic [1:0] {SC_IDLE = 2'b01, SC_RUN = 2'b10} rtdc_scan_e;
  typedef enum logic [1:0] {PR_IDLE = 2'b01, PR_DIV = 2'b10} rtdc_proc_e;
endpackage

// ===== rtdc_div.sv
// serial restoring divider for the window average
`timescale 1ns/100ps
module rtdc_div import rtdc_pkg::*; (
  input wire logic clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic [31:0] dividend,
  input wire logic [6:0] divisor,
  output logic done,
  output logic [31:0] quot
);
  logic [7:0] rem_q;
  logic [6:0] dvs_q;
  logic [5:0] cnt_q;
  logic busy_q;
  logic [7:0] rem_sh;
  logic take;

  always_comb begin
    rem_sh = {rem_q[6:0], quot[31]};
    take = rem_sh >= {1'b0, dvs_q};
  end

  // one quotient bit per cycle; fine since samples arrive a slot apart
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rem_q <= 8'h00;
      dvs_q <= 7'h01;
      cnt_q <= 6'h00;
      busy_q <= 1'b0;
      done <= 1'b0;
      quot <= 32'h00000000;
    end else if (start) begin
      rem_q <= 8'h00;
      dvs_q <= divisor;
      cnt_q <= DIV_STEPS;
      busy_q <= 1'b1;
      done <= 1'b0;
      quot <= dividend;
    end else if (busy_q) begin
      rem_q <= take ? rem_sh - {1'b0, dvs_q} : rem_sh;
      quot <= {quot[30:0], take};
      cnt_q <= cnt_q - 6'h01;
      busy_q <= cnt_q != 6'h01;
      done <= cnt_q == 6'h01;
    end else begin
      done <= 1'b0;
    end
  end
endmodule // rtdc_div

// ===== rtdc_top.sv
// four-channel rtd conditioning: scan, calibrate, average, detect, interrupt
`timescale 1ns/100ps
// How it works
// - disabled channels are skipped by the scan
// - result reported in Celsius or Fahrenheit
// - per-channel gain and offset correction
// - out-of-range gain or offset writes refused
// - averaging window length one to hundred
// - window is a queue: newest in, oldest out
// - disconnection checked on enabled channels only
// - open input raises channel disconnection alarm
// - input beyond range: alarm or warning, configurable
// - warning lamp blinks or stays lit, configurable
// - detection interrupts; host routine number 40..251
// - four independent channels
// - slot 150 ms, or 300 ms three-wire
module rtdc_top import rtdc_pkg::*; #(
  parameter int SLOT_2W_CYC_P = SLOT_2W_CYC,
  parameter int SLOT_3W_CYC_P = SLOT_3W_CYC,
  parameter int BLINK_CYC_P = BLINK_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic afe_valid,
  input wire logic signed [DW-1:0] afe_data,
  input wire logic afe_open,
  input wire logic afe_range_err,
  output logic conv_start,
  output logic [1:0] conv_chan,
  output logic conv_three_wire,
  output logic irq,
  output logic fault_indicator_lamp,
  output logic [7:0] host_service_routine_number
);
  logic [3:0] en_q, three_q, alm_sel_q;
  logic unit_f_q, blink_en_q;
  logic [STW-1:0] stat_q, mask_q;
  logic [7:0] isr_q;
  logic [15:0] gain_q [NCH];
  logic signed [15:0] ofs_q [NCH];
  logic [6:0] win_q [NCH];
  logic [6:0] cnt_q [NCH];
  logic [6:0] ptr_q [NCH];
  logic signed [SW-1:0] sum_q [NCH];
  logic signed [DW-1:0] res_q [NCH];
  logic signed [CW-1:0] qmem [QDEPTH];
  rtdc_scan_e sc_q;
  rtdc_proc_e pr_q;
  logic [1:0] cur_q, nxt, pr_ch_q;
  logic nxt_ok;
  logic [25:0] slot_cnt_q;
  logic [25:0] blink_cnt_q;
  logic blink_tick, blink_ph_q;
  logic neg_q, div_start_q, div_done;
  logic [31:0] div_quot;
  logic signed [SW-1:0] abs_d;

  // register decode
  logic ch_sel;
  logic [1:0] ch_a;
  logic [3:0] sub;
  logic wr_ctrl, wr_stat, wr_mask, wr_isr, wr_gain, wr_ofs, wr_win;
  logic gain_ok, ofs_ok, win_ok, isr_ok, rej_ev;
  logic [3:0] clr_ch;
  logic [3:0] new_en;

  always_comb begin
    ch_sel = reg_addr[7:6] == A_CH_PAGE;
    ch_a = reg_addr[5:4];
    sub = reg_addr[3:0];
    wr_ctrl = reg_wr && reg_addr == A_CTRL;
    wr_stat = reg_wr && reg_addr == A_STAT;
    wr_mask = reg_wr && reg_addr == A_MASK;
    wr_isr = reg_wr && reg_addr == A_ISR;
    wr_gain = reg_wr && ch_sel && sub == SUB_GAIN;
    wr_ofs = reg_wr && ch_sel && sub == SUB_OFS;
    wr_win = reg_wr && ch_sel && sub == SUB_WIN;
    gain_ok = reg_wdata[31:16] == 16'h0000 && reg_wdata[15:0] >= GAIN_MIN
      && reg_wdata[15:0] <= GAIN_MAX;
    ofs_ok = $signed(reg_wdata) >= 32'(OFS_MIN) && $signed(reg_wdata) <= 32'(OFS_MAX);
    win_ok = reg_wdata >= WIN_MIN && reg_wdata <= WIN_MAX;
    isr_ok = reg_wdata[31:8] == 24'h000000 && reg_wdata[7:0] >= ISR_MIN
      && reg_wdata[7:0] <= ISR_MAX;
    rej_ev = (wr_gain && !gain_ok) || (wr_ofs && !ofs_ok) || (wr_win && !win_ok)
      || (wr_isr && !isr_ok);
    new_en = reg_wdata[CTRL_EN_LSB +: 4];
    // a fresh enable or a new window length restarts that channel's queue
    clr_ch = (wr_ctrl ? new_en & ~en_q : 4'h0)
      | ((wr_win && win_ok) ? 4'(1 << ch_a) : 4'h0);
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      {blink_en_q, unit_f_q, alm_sel_q, three_q, en_q} <= CTRL_RST;
    end else if (wr_ctrl) begin
      en_q <= new_en;
      three_q <= reg_wdata[CTRL_3W_LSB +: 4];
      alm_sel_q <= reg_wdata[CTRL_ALM_LSB +: 4];
      unit_f_q <= reg_wdata[CTRL_UNIT_BIT];
      blink_en_q <= reg_wdata[CTRL_BLINK_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      mask_q <= MASK_RST;
      isr_q <= ISR_RST;
    end else begin
      if (wr_mask) begin
        mask_q <= reg_wdata[STW-1:0];
      end
      if (wr_isr && isr_ok) begin
        isr_q <= reg_wdata[7:0];
      end
    end
  end

  generate
    for (genvar c = 0; c < NCH; c++) begin : g_cfg
      always_ff @(posedge clk) begin
        if (!nrst) begin
          gain_q[c] <= GAIN_RST;
          ofs_q[c] <= OFS_RST;
          win_q[c] <= WIN_RST;
        end else if (ch_a == 2'(c)) begin
          if (wr_gain && gain_ok) begin
            gain_q[c] <= reg_wdata[15:0];
          end
          if (wr_ofs && ofs_ok) begin
            ofs_q[c] <= reg_wdata[15:0];
          end
          if (wr_win && win_ok) begin
            win_q[c] <= reg_wdata[6:0];
          end
        end
      end
    end
  endgenerate

  // scan sequencer: next enabled channel after the current one
  always_comb begin
    nxt = cur_q;
    nxt_ok = 1'b0;
    for (int i = 1; i <= NCH; i++) begin
      if (!nxt_ok && en_q[2'(cur_q + 2'(i))]) begin
        nxt = 2'(cur_q + 2'(i));
        nxt_ok = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sc_q <= SC_IDLE;
      cur_q <= 2'h3;
      slot_cnt_q <= 26'h0;
      conv_start <= 1'b0;
      conv_chan <= 2'h0;
      conv_three_wire <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      unique case (sc_q)
        SC_IDLE: begin
          if (nxt_ok) begin
            sc_q <= SC_RUN;
            cur_q <= nxt;
            conv_start <= 1'b1;
            conv_chan <= nxt;
            conv_three_wire <= three_q[nxt];
            slot_cnt_q <= three_q[nxt] ? 26'(SLOT_3W_CYC_P) : 26'(SLOT_2W_CYC_P);
          end
        end
        SC_RUN: begin
          slot_cnt_q <= slot_cnt_q - 26'h1;
          // dropping the channel mid-slot ends its slot at once
          if (slot_cnt_q == 26'h1 || !en_q[cur_q]) begin
            sc_q <= SC_IDLE;
          end
        end
      endcase
    end
  end

  // sample path: calibrate first, then queue and sum
  logic take_s, disc_ev, range_ev;
  logic signed [32:0] prod;
  logic signed [CW-1:0] cal, old;
  logic [8:0] qidx;
  logic full;
  logic signed [SW-1:0] sum_d;

  always_comb begin
    take_s = afe_valid && sc_q == SC_RUN && en_q[cur_q];
    disc_ev = take_s && afe_open;
    range_ev = take_s && !afe_open && afe_range_err;
    prod = afe_data * $signed({1'b0, gain_q[cur_q]});
    cal = CW'(prod >>> 6) + CW'(ofs_q[cur_q]);
    qidx = 9'(cur_q) * 9'h064 + 9'(ptr_q[cur_q]);
    old = qmem[qidx];
    full = cnt_q[cur_q] == win_q[cur_q];
    sum_d = full ? sum_q[cur_q] - SW'(old) + SW'(cal)
      : sum_q[cur_q] + SW'(cal);
    abs_d = sum_d[SW-1] ? -sum_d : sum_d;
  end

  // a sample arriving while a division runs is dropped; slots are far longer
  logic go;
  assign go = take_s && !afe_open && !afe_range_err && pr_q == PR_IDLE && !clr_ch[cur_q];

  always_ff @(posedge clk) begin
    if (go) begin
      qmem[qidx] <= cal;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      for (int c = 0; c < NCH; c++) begin
        cnt_q[c] <= 7'h00;
        ptr_q[c] <= 7'h00;
        sum_q[c] <= 32'sh0;
      end
    end else begin
      if (go) begin
        sum_q[cur_q] <= sum_d;
        cnt_q[cur_q] <= full ? cnt_q[cur_q] : cnt_q[cur_q] + 7'h01;
        ptr_q[cur_q] <= (ptr_q[cur_q] + 7'h01 == win_q[cur_q]) ? 7'h00
          : ptr_q[cur_q] + 7'h01;
      end
      for (int c = 0; c < NCH; c++) begin
        if (clr_ch[c]) begin
          cnt_q[c] <= 7'h00;
          ptr_q[c] <= 7'h00;
          sum_q[c] <= 32'sh0;
        end
      end
    end
  end

  logic [31:0] abs_q;
  logic [6:0] dvs_q;

  rtdc_div u_div (
    .clk(clk),
    .nrst(nrst),
    .start(div_start_q),
    .dividend(abs_q),
    .divisor(dvs_q),
    .done(div_done),
    .quot(div_quot)
  );

  logic signed [SW-1:0] avg;
  logic signed [50:0] fprod;
  logic signed [SW-1:0] fval;

  always_comb begin
    avg = neg_q ? -$signed(div_quot) : $signed(div_quot);
    fprod = avg * $signed({1'b0, F_MUL});
    fval = SW'(fprod >>> 16) + F_ADD;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pr_q <= PR_IDLE;
      pr_ch_q <= 2'h0;
      neg_q <= 1'b0;
      abs_q <= 32'h0;
      dvs_q <= 7'h01;
      div_start_q <= 1'b0;
      for (int c = 0; c < NCH; c++) begin
        res_q[c] <= 16'sh0;
      end
    end else begin
      div_start_q <= 1'b0;
      unique case (pr_q)
        PR_IDLE: begin
          if (go) begin
            pr_q <= PR_DIV;
            pr_ch_q <= cur_q;
            neg_q <= sum_d[SW-1];
            abs_q <= 32'(abs_d);
            dvs_q <= full ? cnt_q[cur_q] : cnt_q[cur_q] + 7'h01;
            div_start_q <= 1'b1;
          end
        end
        PR_DIV: begin
          if (div_done) begin
            pr_q <= PR_IDLE;
            res_q[pr_ch_q] <= unit_f_q ? DW'(fval >>> 8) : DW'(avg >>> 8);
          end
        end
      endcase
    end
  end

  // status: set wins over a same-cycle write-one-to-clear
  logic [STW-1:0] set_v;
  always_comb begin
    set_v = '0;
    set_v[ST_DISC_LSB + 32'(cur_q)] = disc_ev;
    set_v[ST_RALM_LSB + 32'(cur_q)] = range_ev && alm_sel_q[cur_q];
    set_v[ST_RWRN_LSB + 32'(cur_q)] = range_ev && !alm_sel_q[cur_q];
    set_v[ST_REJ_BIT] = rej_ev;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      stat_q <= '0;
    end else begin
      stat_q <= (stat_q & ~(wr_stat ? reg_wdata[STW-1:0] : '0)) | set_v;
    end
  end

  assign blink_tick = blink_cnt_q == 26'(BLINK_CYC_P - 1);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      blink_cnt_q <= 26'h0;
      blink_ph_q <= 1'b0;
      irq <= 1'b0;
      fault_indicator_lamp <= 1'b0;
      host_service_routine_number <= ISR_RST;
    end else begin
      blink_cnt_q <= blink_tick ? 26'h0 : blink_cnt_q + 26'h1;
      blink_ph_q <= blink_ph_q ^ blink_tick;
      irq <= |(stat_q & mask_q);
      fault_indicator_lamp <= (|stat_q[ST_RWRN_LSB-1:0])
        || ((|stat_q[ST_REJ_BIT-1:ST_RWRN_LSB]) && (!blink_en_q || blink_ph_q));
      host_service_routine_number <= isr_q;
    end
  end

  // read data stands only in the cycle after the strobe
  logic [31:0] rmux;
  always_comb begin
    rmux = 32'h0;
    if (ch_sel) begin
      unique case (sub)
        SUB_GAIN: rmux = {16'h0000, gain_q[ch_a]};
        SUB_OFS: rmux = {16'h0000, ofs_q[ch_a]};
        SUB_WIN: rmux = {25'h0, win_q[ch_a]};
        SUB_RES: rmux = {16'h0000, res_q[ch_a]};
        default: rmux = 32'h0;
      endcase
    end else begin
      unique case (reg_addr)
        A_CTRL: rmux = {18'h0, blink_en_q, unit_f_q, alm_sel_q, three_q, en_q};
        A_STAT: rmux = {19'h0, stat_q};
        A_MASK: rmux = {19'h0, mask_q};
        A_ISR: rmux = {24'h0, isr_q};
        default: rmux = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      reg_rdata <= 32'h0;
    end else begin
      reg_rdata <= reg_rd ? rmux : 32'h0;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_start_enabled;
    (conv_start && !$past(reg_wr)) |-> en_q[conv_chan];
  endproperty
  a_start_enabled: assert property (p_start_enabled) else $error("slot on disabled channel");

  property p_next_slot;
    (sc_q == SC_RUN && slot_cnt_q == 26'h1 && |en_q && !reg_wr) |=> ##1 conv_start;
  endproperty
  a_next_slot: assert property (p_next_slot) else $error("next slot did not start");

  property p_gain_reject;
    (wr_gain && !gain_ok) |=> stat_q[ST_REJ_BIT] && $stable(gain_q[0]);
  endproperty
  a_gain_reject: assert property (p_gain_reject) else $error("bad gain not refused");

  property p_win_fill;
    cnt_q[0] <= win_q[0] || $past(wr_win);
  endproperty
  a_win_fill: assert property (p_win_fill) else $error("window overfilled");

  sequence s_div_run;
    pr_q == PR_DIV;
  endsequence
  property p_div_bound;
    $rose(pr_q == PR_DIV) |-> s_div_run [*8] ##[25:30] pr_q == PR_IDLE;
  endproperty
  a_div_bound: assert property (p_div_bound) else $error("average not stored in time");

  property p_disc;
    disc_ev |=> stat_q[ST_DISC_LSB + 32'($past(cur_q))] ##1 fault_indicator_lamp;
  endproperty
  a_disc: assert property (p_disc) else $error("disconnection alarm missing");

  property p_warn;
    (range_ev && !alm_sel_q[cur_q]) |=> stat_q[ST_RWRN_LSB + 32'($past(cur_q))];
  endproperty
  a_warn: assert property (p_warn) else $error("range warning missing");

  property p_irq;
    (|(stat_q & mask_q)) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");
endmodule // rtdc_top

// ===== rtdc_afe_model.sv
// front-end model: answers each slot start with one sample
`timescale 1ns/100ps
module rtdc_afe_model import rtdc_pkg::*; (
  input wire logic clk,
  input wire logic nrst,
  input wire logic conv_start,
  input wire logic [1:0] conv_chan,
  input wire logic conv_three_wire,
  input wire logic [3:0][15:0] raw,
  input wire logic [3:0] open_sel,
  input wire logic [3:0] rng_sel,
  output logic afe_valid,
  output logic signed [DW-1:0] afe_data,
  output logic afe_open,
  output logic afe_range_err
);
  int cnt_q = 0;
  initial {afe_valid, afe_data, afe_open, afe_range_err} = '0;
  always @(posedge clk) begin
    afe_valid <= 1'b0;
    // idle lines toggle so a stale value never passes for data
    afe_data <= ~afe_data;
    afe_open <= ~afe_open;
    afe_range_err <= ~afe_range_err;
    // slow answer on three-wire slots, still inside the longer slot
    if (!nrst) cnt_q <= 0;
    else if (conv_start) cnt_q <= conv_three_wire ? 40 : 4;
    else if (cnt_q > 0) cnt_q <= cnt_q - 1;
    if (nrst && cnt_q == 1) begin
      afe_valid <= 1'b1;
      afe_data <= raw[conv_chan];
      afe_open <= open_sel[conv_chan];
      afe_range_err <= rng_sel[conv_chan];
    end
  end
endmodule // rtdc_afe_model

// ===== tb_top.sv
// bench: registers, scan, averaging and detection against a queue model
`timescale 1ns/100ps
module tb_top import rtdc_pkg::*;;
  localparam int S2 = 50;
  localparam int S3 = 100;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h00000000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, v;
  logic afe_valid, afe_open, afe_range_err, conv_start, conv_three_wire;
  logic irq, lamp, rej;
  logic signed [DW-1:0] afe_data;
  logic [1:0] conv_chan;
  logic [7:0] hsr, isr = 8'h28;
  logic [3:0][15:0] raw = '0;
  logic [3:0] open_sel = 4'h0;
  logic [3:0] rng_sel = 4'h0;
  logic [13:0] ctl = CTRL_RST;
  logic [31:0] tv[4][4] = '{'{32'h3999, 32'h399A, 32'h4666, 32'h4667},
    '{32'hFFFFFEFF, 32'hFFFFFF00, 32'h100, 32'h101}, '{32'h0, 32'h1, 32'h64, 32'h65},
    '{32'h27, 32'h28, 32'hFB, 32'hFC}};
  int fail_count = 0;
  int compares = 0;
  int gcnt = 0;
  int last = 0;
  int sm;
  int lit;
  int q[4][$];
  int gain[4] = '{4{int'(GAIN_RST)}};
  int ofs[4] = '{4{0}};
  int win[4] = '{4{1}};
  int er[4] = '{4{0}};
  int gap[4] = '{4{0}};
  always #2.5 clk = ~clk;
  rtdc_top #(.SLOT_2W_CYC_P(S2), .SLOT_3W_CYC_P(S3), .BLINK_CYC_P(8)) dut (
    .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .afe_valid(afe_valid),
    .afe_data(afe_data), .afe_open(afe_open), .afe_range_err(afe_range_err),
    .conv_start(conv_start), .conv_chan(conv_chan), .conv_three_wire(conv_three_wire),
    .irq(irq), .fault_indicator_lamp(lamp), .host_service_routine_number(hsr));
  rtdc_afe_model afe (.clk(clk), .nrst(nrst), .conv_start(conv_start),
    .conv_chan(conv_chan), .conv_three_wire(conv_three_wire), .raw(raw),
    .open_sel(open_sel), .rng_sel(rng_sel), .afe_valid(afe_valid), .afe_data(afe_data),
    .afe_open(afe_open), .afe_range_err(afe_range_err));
  task automatic summarize();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic [7:0] ch(int c, int s);
    return 8'(8'h40 + 16 * c + s);
  endfunction
  task automatic waitv();
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (afe_valid !== 1'b1 && k < 400);
    if (k >= 400) chk("sample", 1, 0);
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    v = reg_rdata;
  endtask
  // writes land just after a sample, so the model never races a conversion
  task automatic put(logic [7:0] a, logic [31:0] d);
    int c;
    c = int'(a[5:4]);
    rej = 1'b0;
    if (a[7:6] == 2'h1 && a[3:0] == SUB_GAIN) rej = d < 32'h399A || d > 32'h4666;
    if (a[7:6] == 2'h1 && a[3:0] == SUB_OFS) rej = $signed(d) < -256 || $signed(d) > 256;
    if (a[7:6] == 2'h1 && a[3:0] == SUB_WIN) rej = d < 1 || d > 100;
    if (a == A_ISR) rej = d < 40 || d > 251;
    waitv();
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (rej) return;
    if (a == A_CTRL) begin
      for (int j = 0; j < 4; j++) if (d[j] && !ctl[j]) q[j].delete();
      ctl = d[13:0];
    end
    if (a == A_ISR) isr = d[7:0];
    if (a[7:6] == 2'h1) case (a[3:0])
      SUB_GAIN: gain[c] = int'(d);
      SUB_OFS: ofs[c] = int'(d);
      SUB_WIN: begin
        win[c] = int'(d);
        q[c].delete();
      end
      default: ;
    endcase
  endtask
  task automatic samp(int n);
    int c;
    repeat (n) begin
      waitv();
      c = conv_chan;
      repeat (42) @(posedge clk);
      rd(ch(c, SUB_RES));
      chk("result", 32'(er[c]) & 32'hFFFF, v);
    end
  endtask
  always @(posedge clk) begin
    gcnt++;
    if (nrst && conv_start === 1'b1) begin
      chk("scan enabled", 1, {31'h0, ctl[conv_chan]});
      chk("three wire", {31'h0, ctl[4 + conv_chan]}, {31'h0, conv_three_wire});
      gap[last] = gcnt;
      gcnt = 0;
      last = conv_chan;
    end
    if (nrst && afe_valid === 1'b1 && ctl[conv_chan] && !afe_open && !afe_range_err) begin
      q[conv_chan].push_back(((int'(afe_data) * gain[conv_chan]) >>> 6) + ofs[conv_chan]);
      if (q[conv_chan].size() > win[conv_chan]) void'(q[conv_chan].pop_front());
      sm = 0;
      for (int i = 0; i < q[conv_chan].size(); i++) sm += q[conv_chan][i];
      sm = sm / q[conv_chan].size();
      if (ctl[12]) sm = int'((longint'(sm) * 117965) >>> 16) + 81920;
      er[conv_chan] = sm >>> 8;
    end
  end
  initial begin
    #(30000 * 5);
    fail_count++;
    summarize();
  end
  initial begin
    void'($urandom(70));
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk("isr out", 32'h28, {24'h0, hsr});
    chk("irq", 0, {31'h0, irq});
    rd(A_CTRL);
    chk("ctrl", 32'h000F, v);
    rd(A_ISR);
    chk("isr", 32'h28, v);
    rd(A_MASK);
    chk("mask", 0, v);
    rd(8'h30);
    chk("unmapped", 0, v);
    for (int j = 0; j < 4; j++) begin
      rd(ch(j, SUB_GAIN));
      chk("gain", 32'h4000, v);
      rd(ch(j, SUB_WIN));
      chk("window", 1, v);
    end
    for (int k = 0; k < 4; k++) for (int j = 0; j < 4; j++) begin
      put(k < 3 ? ch(j, 4 * k) : A_ISR, tv[k][j]);
      rd(k < 3 ? ch(j, 4 * k) : A_ISR);
      chk("field", k == 0 ? 32'(gain[j]) : k == 1 ? 32'(ofs[j]) & 32'hFFFF :
        k == 2 ? 32'(win[j]) : {24'h0, isr}, v);
      rd(A_STAT);
      chk("reject", {31'h0, rej}, {31'h0, v[12]});
      put(A_STAT, 32'h1000);
    end
    chk("isr out", {24'h0, isr}, {24'h0, hsr});
    for (int j = 0; j < 4; j++) begin
      put(ch(j, SUB_GAIN), 32'h399A + $urandom % 32'hCCD);
      put(ch(j, SUB_OFS), 32'($urandom % 513) - 32'h100);
      put(ch(j, SUB_WIN), 32'h1 + $urandom % 4);
      raw[j] <= 16'(100 + $urandom % 900);
    end
    put(A_CTRL, 32'h0045);
    samp(8);
    chk("slot", S3 - S2, 32'(gap[2] - gap[0]));
    put(ch(2, SUB_WIN), 32'h64);
    samp(6);
    put(A_CTRL, 32'h1045);
    samp(4);
    // channels 1 and 3 are off, so their open inputs must stay unseen
    open_sel <= 4'hB;
    rng_sel <= 4'h4;
    put(A_MASK, 32'h1);
    put(A_CTRL, 32'h2445);
    put(A_STAT, 32'h1FFF);
    samp(2);
    rd(A_STAT);
    chk("status", 32'h41, v);
    chk("irq", 1, {31'h0, irq});
    chk("lamp", 1, {31'h0, lamp});
    open_sel <= 4'h0;
    rng_sel <= 4'h1;
    put(A_STAT, 32'h1FFF);
    samp(2);
    rd(A_STAT);
    chk("status", 32'h100, v);
    chk("irq", 0, {31'h0, irq});
    // own counter: the sample model rewrites its sum at every sample
    lit = 0;
    repeat (20) @(posedge clk) lit += lamp;
    chk("blink", 1, {31'h0, lit > 0 && lit < 20});
    put(A_CTRL, 32'h0445);
    put(A_MASK, 32'h100);
    lit = 0;
    repeat (20) @(posedge clk) lit += lamp;
    chk("steady", 20, lit);
    chk("irq", 1, {31'h0, irq});
    rng_sel <= 4'h0;
    put(A_STAT, 32'h1FFF);
    repeat (3) @(posedge clk);
    chk("irq", 0, {31'h0, irq});
    chk("lamp", 0, {31'h0, lamp});
    summarize();
  end
endmodule // tb_top
